//--- core/hbs_host_port.sv
// Host expansion bus slave port with on-chip packet buffer
//
// How it works
// RULE_01: Address and high-byte enable follow pins, held after latch enable falls.
// RULE_02: Address enable high blocks every I/O decode.
// RULE_03: Memory decode ignores address enable.
// RULE_04: Direction outputs stay high while data flows host to device.
// RULE_05: Direction outputs go low for device reads and PROM reads.
// RULE_06: Channel ready is only ever pulled low, open drain.
// RULE_07: Channel ready is pulled low until read data is ready.
// RULE_08: I/O read of a selected location drives its register data.
// RULE_09: I/O write pulse loads data into the selected register.
// RULE_10: Sixteen-bit data bus, per-lane output enables, pull-ups external.
// RULE_11: Host address selects memory, I/O and external ROM locations.
// RULE_12: Eight-bit and sixteen-bit transfers both supported.
// RULE_13: Decoder yields RAM, PROM and I/O selects.
// RULE_14: RAM reachable by memory cycles or the sequential I/O data port.
// RULE_15: 2K by 8 buffer holds four pages for packets of 508 bytes.
// RULE_16: Writes complete with no wait states.
// RULE_17: Memory read drives RAM data; PROM reads go to the external part.
// RULE_18: Memory write pulse stores data into the RAM.
// RULE_19: Upper lane moves only when high-byte enable is low.
// RULE_20: Zero-wait output is open drain, pulled low on writes to us.
// RULE_21: Direction outputs rest high when no read to us or the PROM.
module hbs_host_port (
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_arst_n, // Async reset, active low
  input wire hbs_pkg::hbs_bus_in_type i_bus, // Host bus pins in
  output hbs_pkg::hbs_bus_out_type o_bus, // Host bus pins out
  input wire logic [8:0] i_ram_base, // RAM window, A19-A11
  input wire logic [5:0] i_rom_base, // PROM window, A19-A14
  input wire logic [11:0] i_io_base, // I/O block, A15-A4
  input wire logic i_rom_en_n, // PROM decode enable
  output logic o_reg_wr, // Register write pulse
  output logic [3:0] o_reg_idx, // Register offset
  output logic [7:0] o_reg_wdata, // Register write data
  input wire logic [7:0] i_reg_rdata, // Register read data
  input wire logic [10:0] i_core_addr, // Core buffer address
  input wire logic i_core_we, // Core buffer write
  input wire logic [7:0] i_core_wdata, // Core buffer write data
  output logic [7:0] o_core_rdata // Core buffer read data
);
  import hbs_pkg::*;

  // ---------------------------------------------------------------
  // Address latch
  // ---------------------------------------------------------------
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic sbhe_r, sbhe_nxt;
  logic [ADDR_W-1:0] ea;
  logic ea_sbhe_n;

  always_comb begin
    addr_nxt = addr_r;
    sbhe_nxt = sbhe_r;
    if (i_bus.bale) begin
      addr_nxt = i_bus.addr; // RULE_01
      sbhe_nxt = i_bus.sbhe_n; // RULE_01
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_r <= ADDR_RST;
      sbhe_r <= 1'b1;
    end else begin
      addr_r <= addr_nxt;
      sbhe_r <= sbhe_nxt;
    end
  end

  // Transparent while latch enable is high, frozen once it falls
  assign ea = i_bus.bale ? i_bus.addr : addr_r; // RULE_01
  assign ea_sbhe_n = i_bus.bale ? i_bus.sbhe_n : sbhe_r;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic io_hit, ram_hit, rom_hit;
  logic io_rd, mem_rd, rom_rd, rd_any;
  logic io_wr, mem_wr, wr_any;
  logic seq_sel;

  assign io_hit = !i_bus.aen && (ea[IO_WIN_MSB:IO_WIN_LSB] == i_io_base); // RULE_02 RULE_11 RULE_13
  assign ram_hit = ea[ADDR_W-1:RAM_WIN_LSB] == i_ram_base; // RULE_03 RULE_13
  assign rom_hit = !i_rom_en_n && !ram_hit
    && (ea[ADDR_W-1:ROM_WIN_LSB] == i_rom_base); // RULE_11 RULE_13
  assign seq_sel = ea[3:0] == IO_DATA_PORT; // RULE_14
  assign io_rd = !i_bus.ior_n && io_hit; // RULE_08
  assign mem_rd = !i_bus.memr_n && ram_hit; // RULE_17
  assign rom_rd = !i_bus.memr_n && rom_hit; // RULE_17
  assign rd_any = io_rd || mem_rd;
  assign io_wr = !i_bus.iow_n && io_hit; // RULE_09
  assign mem_wr = !i_bus.memw_n && ram_hit; // RULE_18
  assign wr_any = io_wr || mem_wr;

  // ---------------------------------------------------------------
  // Buffer RAM
  // ---------------------------------------------------------------
  logic [RAM_AW-1:0] ptr_r, ptr_nxt;
  logic [RAM_AW-1:0] rd_badr;
  logic [BANK_AW-1:0] ram_addr;
  logic [1:0] ram_we;
  logic [15:0] ram_wdata, ram_q;
  logic commit;
  logic [RAM_AW-1:0] wadr_r, wadr_nxt;
  logic [15:0] wdat_r, wdat_nxt;
  logic wsbhe_r, wsbhe_nxt;
  logic wram_r, wram_nxt;
  logic wseq_r, wseq_nxt;
  logic wpend_r, wpend_nxt;
  logic [3:0] widx_r, widx_nxt;

  assign rd_badr = (io_rd && seq_sel) ? ptr_r : ea[RAM_AW-1:0]; // RULE_14
  assign ram_addr = commit ? wadr_r[RAM_AW-1:1] : rd_badr[RAM_AW-1:1];
  // Odd byte from an 8-bit host arrives on the low lane
  assign ram_wdata = {(wadr_r[0] && wsbhe_r) ? wdat_r[7:0] : wdat_r[15:8], wdat_r[7:0]};
  assign ram_we = (commit && wram_r) ? {wadr_r[0] || !wsbhe_r, !wadr_r[0]} : 2'b00; // RULE_12 RULE_19

  hbs_buf_ram #(
    .AW(BANK_AW) // RULE_15
  ) u_ram (
    .i_ref_clk(i_ref_clk),
    .i_a_addr(ram_addr),
    .i_a_we(ram_we),
    .i_a_wdata(ram_wdata),
    .o_a_rdata(ram_q),
    .i_b_addr(i_core_addr),
    .i_b_we(i_core_we),
    .i_b_wdata(i_core_wdata),
    .o_b_rdata(o_core_rdata)
  );

  // Step of the sequential pointer: a word moves it by two
  function automatic logic [RAM_AW-1:0] ptr_step(input logic a0, input logic sbhe_n);
    ptr_step = (!a0 && !sbhe_n) ? 11'h002 : 11'h001;
  endfunction : ptr_step

  // ---------------------------------------------------------------
  // Write path: capture while the strobe is low, commit on its release
  // ---------------------------------------------------------------
  assign commit = wpend_r && i_bus.iow_n && i_bus.memw_n; // RULE_09 RULE_18

  always_comb begin
    wpend_nxt = wpend_r;
    wadr_nxt = wadr_r;
    wdat_nxt = wdat_r;
    wsbhe_nxt = wsbhe_r;
    wram_nxt = wram_r;
    wseq_nxt = wseq_r;
    widx_nxt = widx_r;
    if (wr_any) begin
      wpend_nxt = 1'b1;
      wadr_nxt = (io_wr && seq_sel) ? ptr_r : ea[RAM_AW-1:0]; // RULE_14
      wdat_nxt = i_bus.data; // RULE_10
      wsbhe_nxt = ea_sbhe_n;
      wram_nxt = mem_wr || seq_sel;
      wseq_nxt = io_wr && seq_sel;
      widx_nxt = ea[3:0];
    end else if (commit) begin
      wpend_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      wpend_r <= 1'b0;
      wadr_r <= PTR_RST;
      wdat_r <= DATA_RST;
      wsbhe_r <= 1'b1;
      wram_r <= 1'b0;
      wseq_r <= 1'b0;
      widx_r <= 4'h0;
    end else begin
      wpend_r <= wpend_nxt;
      wadr_r <= wadr_nxt;
      wdat_r <= wdat_nxt;
      wsbhe_r <= wsbhe_nxt;
      wram_r <= wram_nxt;
      wseq_r <= wseq_nxt;
      widx_r <= widx_nxt;
    end
  end

  assign o_reg_wr = commit && !wram_r; // RULE_09
  assign o_reg_idx = wpend_r ? widx_r : ea[3:0];
  assign o_reg_wdata = wdat_r[7:0];

  // ---------------------------------------------------------------
  // Read sequencer
  // ---------------------------------------------------------------
  hbs_state_type st_r, st_nxt;
  logic [15:0] data_r, data_nxt;
  logic [1:0] oe_r, oe_nxt;
  logic rram_r, rram_nxt;
  logic rseq_r, rseq_nxt;
  logic [1:0] rlane_r, rlane_nxt;
  logic ra0_r, ra0_nxt;
  logic rsbhe_r, rsbhe_nxt;
  logic rd_end;

  assign rd_end = i_bus.ior_n && i_bus.memr_n;

  always_comb begin
    st_nxt = st_r;
    data_nxt = data_r;
    oe_nxt = oe_r;
    rram_nxt = rram_r;
    rseq_nxt = rseq_r;
    rlane_nxt = rlane_r;
    ra0_nxt = ra0_r;
    rsbhe_nxt = rsbhe_r;
    case (st_r)
      ST_IDLE: begin
        oe_nxt = 2'b00;
        if (rd_any) begin
          st_nxt = ST_FETCH;
          rram_nxt = mem_rd || seq_sel; // RULE_14 RULE_17
          rseq_nxt = io_rd && seq_sel;
          ra0_nxt = rd_badr[0];
          rsbhe_nxt = ea_sbhe_n;
          rlane_nxt = hbs_lanes(rd_badr[0], ea_sbhe_n); // RULE_12 RULE_19
        end
      end
      ST_FETCH: begin
        st_nxt = ST_DRIVE;
        oe_nxt = rlane_r; // RULE_10
        if (rram_r) begin
          data_nxt = {ram_q[15:8], ra0_r ? ram_q[15:8] : ram_q[7:0]}; // RULE_17
        end else begin
          data_nxt = {i_reg_rdata, i_reg_rdata}; // RULE_08
        end
      end
      ST_DRIVE: begin
        if (rd_end) begin
          st_nxt = ST_IDLE;
          oe_nxt = 2'b00;
        end
      end
      default: begin
        st_nxt = ST_IDLE;
        oe_nxt = 2'b00;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= ST_IDLE;
      data_r <= DATA_RST;
      oe_r <= 2'b00;
      rram_r <= 1'b0;
      rseq_r <= 1'b0;
      rlane_r <= 2'b00;
      ra0_r <= 1'b0;
      rsbhe_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      data_r <= data_nxt;
      oe_r <= oe_nxt;
      rram_r <= rram_nxt;
      rseq_r <= rseq_nxt;
      rlane_r <= rlane_nxt;
      ra0_r <= ra0_nxt;
      rsbhe_r <= rsbhe_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Sequential access pointer
  // ---------------------------------------------------------------
  always_comb begin
    ptr_nxt = ptr_r;
    if (commit && wseq_r) begin
      ptr_nxt = ptr_r + ptr_step(wadr_r[0], wsbhe_r); // RULE_14
    end else if (commit && widx_r == IO_PTR_LO) begin
      ptr_nxt = {ptr_r[10:8], wdat_r[7:0]};
    end else if (commit && widx_r == IO_PTR_HI) begin
      ptr_nxt = {wdat_r[2:0], ptr_r[7:0]};
    end else if (st_r == ST_DRIVE && rd_end && rseq_r) begin
      ptr_nxt = ptr_r + ptr_step(ra0_r, rsbhe_r); // RULE_14
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ptr_r <= PTR_RST;
    end else begin
      ptr_r <= ptr_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic xcvr_out;

  // Transceiver turns outward only for our reads or PROM reads
  assign xcvr_out = rd_any || rom_rd; // RULE_05 RULE_21

  always_comb begin
    o_bus.data = data_r; // RULE_10
    o_bus.data_oe = oe_r; // RULE_19
    o_bus.xcvr_dir_low_byte_n = !xcvr_out; // RULE_04 RULE_05
    o_bus.xcvr_dir_high_byte_n = !xcvr_out; // RULE_04 RULE_05
    o_bus.chan_rdy_o = 1'b0; // RULE_06
    // Stretch until the read data, RAM or register, has been registered onto the pins
    o_bus.chan_rdy_oe = (st_r == ST_IDLE && rd_any) || st_r == ST_FETCH; // RULE_07
    o_bus.zero_wait_request_n = 1'b0; // RULE_20
    o_bus.zero_wait_oe = wr_any; // RULE_16 RULE_20
    o_bus.prom_sel_n = !rom_rd; // RULE_13
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);

  sequence s_rd_start;
    st_r == ST_IDLE && rd_any && !i_bus.ior_n;
  endsequence

  sequence s_drive;
    st_r == ST_FETCH ##1 (o_bus.data_oe != 2'b00);
  endsequence

  AST_ADDR_HOLD: assert property (!i_bus.bale [*2] |-> $stable(addr_r)) // RULE_01
    else $error("address latch moved while closed");
  AST_AEN_BLOCK: assert property (i_bus.aen && i_bus.memr_n |-> o_bus.xcvr_dir_low_byte_n) // RULE_02
    else $error("I/O read decoded with address enable high");
  AST_MEM_NO_AEN: assert property (st_r == ST_IDLE && mem_rd && i_bus.aen |=> s_drive) // RULE_03
    else $error("memory read blocked by address enable");
  AST_DIR_REST: assert property (rd_end |-> o_bus.xcvr_dir_low_byte_n
    && o_bus.xcvr_dir_high_byte_n) // RULE_21
    else $error("transceiver not inbound at rest");
  AST_DIR_OUT: assert property (st_r == ST_DRIVE && !rd_end |-> !o_bus.xcvr_dir_high_byte_n) // RULE_05
    else $error("transceiver not outbound while driving");
  AST_CHRDY_OD: assert property (o_bus.chan_rdy_oe |-> o_bus.data_oe == 2'b00) // RULE_06
    else $error("ready stretched while data driven");
  AST_CHRDY_REL: assert property (s_rd_start |-> o_bus.chan_rdy_oe ##1 o_bus.chan_rdy_oe
    ##1 !o_bus.chan_rdy_oe) // RULE_07
    else $error("ready stretch not two cycles");
  AST_IO_READ: assert property (s_rd_start ##1 (!rram_r && !i_bus.ior_n)
    |=> o_bus.data[7:0] == $past(i_reg_rdata)) // RULE_08
    else $error("register data not driven");
  AST_IO_WRITE: assert property (io_wr && !seq_sel ##1 !io_wr && !mem_wr
    && i_bus.iow_n && i_bus.memw_n |-> o_reg_wr) // RULE_09
    else $error("register write not issued on strobe release");
  AST_HI_LANE: assert property (st_r == ST_IDLE && rd_any && ea_sbhe_n
    |-> ##2 !o_bus.data_oe[1]) // RULE_19
    else $error("upper lane driven without high enable");
  AST_ZWS: assert property (o_bus.zero_wait_oe |-> !(i_bus.iow_n && i_bus.memw_n)) // RULE_20
    else $error("zero wait asserted outside a write");

endmodule : hbs_host_port

//--- common/hbs_pkg.sv
// Shared constants, carriers and helpers of the host bus slave port
package hbs_pkg;

  // ---------------------------------------------------------------
  // Widths and buffer geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int RAM_AW = 11;
  localparam int BANK_AW = 10;
  localparam int PAGE_BYTES = 512;
  localparam int PAGES = 4;
  localparam int PKT_MAX_BYTES = 508;
  localparam int RAM_BYTES = PAGE_BYTES * PAGES;

  // ---------------------------------------------------------------
  // Decode windows: address bit ranges compared to the base inputs
  // ---------------------------------------------------------------
  localparam int RAM_WIN_LSB = 11;
  localparam int ROM_WIN_LSB = 14;
  localparam int IO_WIN_LSB = 4;
  localparam int IO_WIN_MSB = 15;

  // ---------------------------------------------------------------
  // I/O offsets inside the 16-location block
  // ---------------------------------------------------------------
  localparam logic [3:0] IO_DATA_PORT = 4'h0;
  localparam logic [3:0] IO_PTR_LO = 4'h2;
  localparam logic [3:0] IO_PTR_HI = 4'h3;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [RAM_AW-1:0] PTR_RST = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

  // ---------------------------------------------------------------
  // Pin carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic bale;
    logic [ADDR_W-1:0] addr;
    logic sbhe_n;
    logic aen;
    logic ior_n;
    logic iow_n;
    logic memr_n;
    logic memw_n;
    logic [DATA_W-1:0] data;
  } hbs_bus_in_type;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [1:0] data_oe;
    logic xcvr_dir_low_byte_n;
    logic xcvr_dir_high_byte_n;
    logic chan_rdy_o;
    logic chan_rdy_oe;
    logic zero_wait_request_n;
    logic zero_wait_oe;
    logic prom_sel_n;
  } hbs_bus_out_type;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FETCH = 3'b010,
    ST_DRIVE = 3'b100
  } hbs_state_type;

  // Byte lanes of a transfer; an odd byte on an 8-bit host uses the low lane
  function automatic logic [1:0] hbs_lanes(input logic a0, input logic sbhe_n);
    if (!sbhe_n) begin
      hbs_lanes = a0 ? 2'b10 : 2'b11;
    end else begin
      hbs_lanes = 2'b01;
    end
  endfunction : hbs_lanes

endpackage : hbs_pkg

//--- core/hbs_buf_ram.sv
// Packet buffer RAM: two byte banks, host word port and core byte port
module hbs_buf_ram #(
  parameter int AW = 10 // Address width of one bank
) (
  input wire logic i_ref_clk, // Clock
  input wire logic [AW-1:0] i_a_addr, // Host word address
  input wire logic [1:0] i_a_we, // Host bank write enables
  input wire logic [15:0] i_a_wdata, // Host write data
  output logic [15:0] o_a_rdata, // Host read data
  input wire logic [AW:0] i_b_addr, // Core byte address
  input wire logic i_b_we, // Core write enable
  input wire logic [7:0] i_b_wdata, // Core write data
  output logic [7:0] o_b_rdata // Core read data
);

  logic [7:0] lo_mem [2**AW];
  logic [7:0] hi_mem [2**AW];
  logic [AW-1:0] b_word;

  assign b_word = i_b_addr[AW:1];

  // Host write wins on a same-cycle clash; the core owns a page only
  // while the host leaves it alone.
  always_ff @(posedge i_ref_clk) begin
    if (i_b_we && !i_b_addr[0]) begin
      lo_mem[b_word] <= i_b_wdata;
    end
    if (i_b_we && i_b_addr[0]) begin
      hi_mem[b_word] <= i_b_wdata;
    end
    if (i_a_we[0]) begin
      lo_mem[i_a_addr] <= i_a_wdata[7:0];
    end
    if (i_a_we[1]) begin
      hi_mem[i_a_addr] <= i_a_wdata[15:8];
    end
    o_a_rdata <= {hi_mem[i_a_addr], lo_mem[i_a_addr]};
    o_b_rdata <= i_b_addr[0] ? hi_mem[b_word] : lo_mem[b_word];
  end

endmodule : hbs_buf_ram

//--- sim/hbs_host_model.sv
// Behavioural host processor that runs expansion bus cycles
module hbs_host_model (
  input wire logic i_ref_clk, // Bench clock
  input wire logic [15:0] i_data, // Resolved data wire
  input wire logic i_chan_rdy, // Resolved channel ready
  input wire logic i_side_n, // Direction on reads, zero wait on writes
  output hbs_pkg::hbs_bus_in_type o_bus, // Host pins, data is the host's drive
  output logic o_data_oe // Host drives data
);
  timeunit 1ns;
  timeprecision 100ps;
  import hbs_pkg::*;

  initial begin
    o_bus = '0;
    {o_bus.ior_n, o_bus.iow_n, o_bus.memr_n, o_bus.memw_n} = 4'hF;
    o_data_oe = 1'b0;
  end

  // ---------------------------------------------------------------
  // Kind 0 I/O read, 1 I/O write, 2 memory read, 3 memory write
  // ---------------------------------------------------------------
  task automatic cycle(input logic [1:0] kind, input logic [19:0] addr, input logic sbhe_n,
      input logic aen, input logic [15:0] wdata, output logic [15:0] rdata,
      output logic side_n, output logic ok);
    int n;
    n = 0;
    @(negedge i_ref_clk);
    o_bus.bale = 1'b1;
    o_bus.addr = addr;
    o_bus.sbhe_n = sbhe_n;
    o_bus.aen = aen;
    @(negedge i_ref_clk);
    // Pins move on once latch enable falls, so only a held copy decodes right
    o_bus.bale = 1'b0;
    o_bus.addr = ~addr;
    o_bus.sbhe_n = ~sbhe_n;
    o_bus.data = wdata;
    o_data_oe = kind[0];
    o_bus.ior_n = (kind != 2'd0);
    o_bus.iow_n = (kind != 2'd1);
    o_bus.memr_n = (kind != 2'd2);
    o_bus.memw_n = (kind != 2'd3);
    // Reads wait for channel ready; writes are a one-cycle low pulse
    do begin
      @(negedge i_ref_clk);
      n++;
      side_n = i_side_n;
    end while (!kind[0] && (n < 3 || i_chan_rdy !== 1'b1) && n < 40);
    ok = (n < 40);
    rdata = i_data;
    {o_bus.ior_n, o_bus.iow_n, o_bus.memr_n, o_bus.memw_n} = 4'hF;
    o_data_oe = 1'b0;
    o_bus.data = ~wdata;
    @(negedge i_ref_clk);
  endtask : cycle
endmodule : hbs_host_model

//--- sim/host_expansion_bus_slave_port_bench.sv
// Self-checking bench for the host bus slave port
module host_expansion_bus_slave_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import hbs_pkg::*;

  localparam logic [8:0] RAM_BASE = 9'h1A0;
  localparam logic [5:0] ROM_BASE = 6'h38;
  localparam logic [11:0] IO_BASE = 12'h02E;
  logic i_ref_clk;
  logic i_arst_n;
  hbs_bus_in_type host_bus;
  hbs_bus_in_type bus_in;
  hbs_bus_out_type dev;
  logic host_oe;
  logic [15:0] wire_d;
  logic chan_rdy;
  logic zws_n;
  logic side_n;
  logic psel_n;
  logic reg_wr;
  logic [3:0] reg_idx;
  logic [7:0] reg_wdata;
  logic [3:0] key;
  logic [3:0] lw_idx;
  logic [7:0] lw_dat;
  logic [10:0] core_addr;
  logic core_we;
  logic [7:0] core_wdata;
  logic [7:0] core_rdata;
  logic [7:0] mem_m [0:2047];
  int failures;
  int comparisons;
  int wr_cnt;
  int seed;

  // ---------------------------------------------------------------
  // Wire resolution: device lanes, else host, else pull-ups
  // ---------------------------------------------------------------
  always_comb begin
    for (int b = 0; b < 2; b++) begin
      wire_d[8*b+:8] = dev.data_oe[b] ? dev.data[8*b+:8] :
        (host_oe ? host_bus.data[8*b+:8] : 8'hFF);
    end
    bus_in = host_bus;
    bus_in.data = wire_d;
    chan_rdy = dev.chan_rdy_oe ? dev.chan_rdy_o : 1'b1;
    zws_n = dev.zero_wait_oe ? dev.zero_wait_request_n : 1'b1;
    side_n = (host_bus.iow_n && host_bus.memw_n) ? dev.xcvr_dir_low_byte_n : zws_n;
  end

  hbs_host_port dut_u (
    .i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_bus(bus_in), .o_bus(dev),
    .i_ram_base(RAM_BASE), .i_rom_base(ROM_BASE), .i_io_base(IO_BASE), .i_rom_en_n(1'b0),
    .o_reg_wr(reg_wr), .o_reg_idx(reg_idx), .o_reg_wdata(reg_wdata),
    .i_reg_rdata({key, reg_idx}), .i_core_addr(core_addr), .i_core_we(core_we),
    .i_core_wdata(core_wdata), .o_core_rdata(core_rdata));

  hbs_host_model host_u (.i_ref_clk(i_ref_clk), .i_data(wire_d), .i_chan_rdy(chan_rdy),
    .i_side_n(side_n), .o_bus(host_bus), .o_data_oe(host_oe));

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end

  // ---------------------------------------------------------------
  // Checks, expectations and host cycles
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check16(input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check16

  task automatic check1(input logic exp, input logic got);
    check16({15'h0000, exp}, {15'h0000, got});
  endtask : check1

  function automatic logic [15:0] exp_rd(input logic [10:0] o, input logic sb);
    if (sb) return {8'hFF, mem_m[o]};
    if (o[0]) return {mem_m[o], 8'hFF};
    return {mem_m[o+11'h001], mem_m[o]};
  endfunction : exp_rd

  task automatic put(input logic [10:0] o, input logic sb, input logic [15:0] d);
    if (sb) mem_m[o] = d[7:0];
    else if (o[0]) mem_m[o] = d[15:8];
    else begin
      mem_m[o] = d[7:0];
      mem_m[o+11'h001] = d[15:8];
    end
  endtask : put

  function automatic logic [19:0] io(input logic [3:0] off);
    return {4'h0, IO_BASE, off};
  endfunction : io

  task automatic run(input logic [1:0] kind, input logic [19:0] a, input logic sb,
      input logic aen, input logic [15:0] wd, output logic [15:0] rd, output logic sd);
    logic ok;
    host_u.cycle(kind, a, sb, aen, wd, rd, sd, ok);
    if (!ok) begin
      failures++;
      summarize();
    end
  endtask : run

  always @(posedge i_ref_clk) begin
    if (reg_wr === 1'b1) begin
      wr_cnt++;
      lw_idx = reg_idx;
      lw_dat = reg_wdata;
    end
  end

  // Inbound direction during writes; channel ready never driven high
  always @(negedge i_ref_clk) begin
    if (i_arst_n && !(host_bus.iow_n && host_bus.memw_n)) begin
      check16(16'h0003, {14'h0, dev.xcvr_dir_high_byte_n, dev.xcvr_dir_low_byte_n});
    end
    if (dev.chan_rdy_oe === 1'b1) check1(1'b0, dev.chan_rdy_o);
    // Last PROM select seen while a memory read strobe is low
    if (!host_bus.memr_n) psel_n = dev.prom_sel_n;
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [15:0] rd;
    logic [15:0] d;
    logic [10:0] o;
    logic [1:0] k;
    logic sb;
    logic sd;
    int cnt;
    seed = 24858;
    failures = 0;
    comparisons = 0;
    wr_cnt = 0;
    i_arst_n = 1'b0;
    key = 4'h0;
    core_addr = 11'h000;
    core_we = 1'b0;
    core_wdata = 8'h00;
    repeat (5) @(negedge i_ref_clk);
    i_arst_n = 1'b1;
    check16(16'h0003, {14'h0, dev.xcvr_dir_high_byte_n, dev.xcvr_dir_low_byte_n});
    // Known buffer contents first, so every host read has an expectation
    for (int i = 0; i < 2048; i++) begin
      core_addr = i[10:0];
      core_we = 1'b1;
      core_wdata = 8'($random(seed));
      mem_m[i] = core_wdata;
      @(negedge i_ref_clk);
    end
    core_we = 1'b0;
    for (int j = 4; j < 16; j += 5) begin
      d = {8'h00, 8'($random(seed))};
      key = 4'($random(seed));
      run(2'd1, io(4'(j)), 1'b1, 1'b0, d, rd, sd);
      check16({12'h000, 4'(j)}, {12'h000, lw_idx});
      check16(d, {8'h00, lw_dat});
      check1(1'b0, sd);
      run(2'd0, io(4'(j)), 1'b1, 1'b0, 16'h0000, rd, sd);
      check16({8'hFF, key, 4'(j)}, rd);
      check1(1'b0, sd);
    end
    cnt = wr_cnt;
    run(2'd1, io(4'h5), 1'b1, 1'b1, 16'h005A, rd, sd);
    check16(16'(cnt), 16'(wr_cnt));
    run(2'd0, io(4'h5), 1'b1, 1'b1, 16'h0000, rd, sd);
    check16(16'hFFFF, rd);
    check1(1'b1, sd);
    run(2'd2, 20'h00100, 1'b0, 1'b0, 16'h0000, rd, sd);
    check16(16'hFFFF, rd);
    run(2'd2, {ROM_BASE, 14'h0123}, 1'b1, 1'b0, 16'h0000, rd, sd);
    check1(1'b0, sd);
    check1(1'b0, psel_n);
    check16(16'hFFFF, rd);
    for (int p = 0; p < 2; p++) begin
      run(2'd1, io(4'h2), 1'b1, 1'b0, 16'h00FD, rd, sd);
      run(2'd1, io(4'h3), 1'b1, 1'b0, 16'h0007, rd, sd);
      for (int i = 0; i < 3; i++) begin
        if (p == 0) begin
          d = {8'h00, 8'($random(seed))};
          mem_m[11'h7FD + i] = d[7:0];
          run(2'd1, io(4'h0), 1'b1, 1'b0, d, rd, sd);
        end else begin
          run(2'd0, io(4'h0), 1'b1, 1'b0, 16'h0000, rd, sd);
          check16(exp_rd(11'(11'h7FD + i), 1'b1), rd);
        end
      end
    end
    run(2'd2, {RAM_BASE, 11'h7FE}, 1'b0, 1'b1, 16'h0000, rd, sd);
    check16(exp_rd(11'h7FE, 1'b0), rd);
    check1(1'b1, psel_n);
    for (int i = 0; i < 80; i++) begin
      k = {1'b1, 1'($random(seed))};
      o = (i == 0) ? 11'h7FF : 11'($random(seed));
      sb = 1'($random(seed));
      d = 16'($random(seed));
      run(k, {RAM_BASE, o}, sb, 1'($random(seed)), d, rd, sd);
      check1(1'b0, sd);
      if (k[0]) begin
        put(o, sb, d);
        run(2'd2, {RAM_BASE, o}, sb, 1'b0, 16'h0000, rd, sd);
        core_addr = o;
        @(negedge i_ref_clk);
        check16({8'h00, mem_m[o]}, {8'h00, core_rdata});
      end
      check16(exp_rd(o, sb), rd);
    end
    summarize();
  end
endmodule : host_expansion_bus_slave_port_bench
